/* File: hdl/ecr_top.v */
// Encoder counter registers reached over an AHB-Lite slave.
//
// Local design decisions: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "ecr_defines.vh"
module ecr_top
#(
    parameter VEL_WIDTH = 16
)
(
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [2:0] hsize_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    output reg [31:0] hrdata_out,
    output reg hreadyout_out,
    output reg hresp_out,
    input wire enc_a_in,
    input wire enc_b_in,
    input wire enc_index_in,
    output reg [31:0] index_count_full_out
);
    // ----------------------------------------------------------------
    // Storage.
    // ----------------------------------------------------------------
    reg [VEL_WIDTH-1:0] velocity_count; // Signed step count since last clear.
    reg [31:0] index_count; // Full index counter.
    reg [15:0] index_count_upper; // Upper half latched on lower read.
    reg [31:0] interval_timer; // Free interval timer between index pulses.
    reg [15:0] interval_hold_upper; // Upper half hold.
    reg [1:0] control; // Count and timer enables.
    // Data-phase bookkeeping.
    reg dp_write;
    reg dp_read;
    reg [7:0] dp_addr;
    // Synchronised encoder pins and their history.
    wire a_level;
    wire b_level;
    wire x_level;
    reg a_prev;
    reg b_prev;
    reg x_prev;

    // ----------------------------------------------------------------
    // Pin synchronisers, one per encoder input.
    // ----------------------------------------------------------------
    // Phase A of the encoder.
    ecr_input_sync u_sync_a
    (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(enc_a_in),
        .level_out(a_level)
    );
    // Phase B of the encoder.
    ecr_input_sync u_sync_b
    (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(enc_b_in),
        .level_out(b_level)
    );
    // Index pulse of the encoder.
    ecr_input_sync u_sync_x
    (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pin_in(enc_index_in),
        .level_out(x_level)
    );

    // ----------------------------------------------------------------
    // Quadrature decoding.
    // ----------------------------------------------------------------
    // A step happens when exactly one phase changes; direction from XOR.
    wire step = (a_level ^ a_prev) ^ (b_level ^ b_prev);
    wire dir_up = a_prev ^ b_level;
    wire index_rise = x_level & ~x_prev;
    wire count_en = control[`ECR_CTRL_COUNT_EN];
    wire timer_en = control[`ECR_CTRL_TIMER_EN];

    // Address phase accepted this cycle.
    wire ap_valid = hsel_in & hready_in & htrans_in[1];
    wire ap_write = ap_valid & hwrite_in;
    wire ap_read = ap_valid & ~hwrite_in;
    wire [7:0] ap_addr = haddr_in[7:0];
    wire [15:0] wdata = hwdata_in[15:0];

    // Data-phase write strobes per register.
    wire wr_vel = dp_write & (dp_addr == `ECR_OFF_VELOCITY_COUNT);
    wire wr_iup = dp_write & (dp_addr == `ECR_OFF_INDEX_COUNT_UPPER);
    wire wr_ilo = dp_write & (dp_addr == `ECR_OFF_INDEX_COUNT_LOWER);
    wire wr_hup = dp_write & (dp_addr == `ECR_OFF_INTERVAL_HOLD_UPPER);
    wire wr_hlo = dp_write & (dp_addr == `ECR_OFF_INTERVAL_HOLD_LOWER);
    wire wr_ctl = dp_write & (dp_addr == `ECR_OFF_CONTROL);
    // Lower-half reads snapshot the upper half for coherence.
    wire rd_ilo = ap_read & (ap_addr == `ECR_OFF_INDEX_COUNT_LOWER);
    wire rd_hlo = ap_read & (ap_addr == `ECR_OFF_INTERVAL_HOLD_LOWER);

    // ----------------------------------------------------------------
    // Bus control: zero wait states, always OKAY.
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            dp_write <= 1'b0;
            dp_read <= 1'b0;
            dp_addr <= 8'h00;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
        else
        begin
            dp_write <= ap_write;
            dp_read <= ap_read;
            dp_addr <= ap_addr;
            hreadyout_out <= 1'b1;
            hresp_out <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Read data: registered in the address phase so it stands in the data phase.
    // ----------------------------------------------------------------
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            hrdata_out <= 32'h00000000;
        end
        else if (ap_read)
        begin
            case (ap_addr)
                `ECR_OFF_VELOCITY_COUNT: hrdata_out <= {16'h0000, velocity_count};
                `ECR_OFF_INDEX_COUNT_UPPER: hrdata_out <= {16'h0000, index_count_upper};
                `ECR_OFF_INDEX_COUNT_LOWER: hrdata_out <= {16'h0000, index_count[15:0]};
                `ECR_OFF_INTERVAL_HOLD_UPPER:
                    hrdata_out <= {16'h0000, interval_hold_upper};
                `ECR_OFF_INTERVAL_HOLD_LOWER:
                    hrdata_out <= {16'h0000, interval_timer[15:0]};
                `ECR_OFF_CONTROL: hrdata_out <= {30'h00000000, control};
                default: hrdata_out <= 32'h00000000;
            endcase
        end
        else
        begin
            hrdata_out <= 32'h00000000;
        end
    end

    // ----------------------------------------------------------------
    // Counters and hold registers.
    // ----------------------------------------------------------------
    // Reading the lower word latches the upper word into its hold; writing the
    // upper hold stages a value that a lower-word write loads together with it.
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            velocity_count <= {VEL_WIDTH{1'b0}};
            index_count <= 32'h00000000;
            index_count_upper <= `ECR_RESET_WORD;
            interval_timer <= 32'h00000000;
            interval_hold_upper <= `ECR_RESET_WORD;
            control <= `ECR_RESET_CTRL;
            a_prev <= 1'b0;
            b_prev <= 1'b0;
            x_prev <= 1'b0;
            index_count_full_out <= 32'h00000000;
        end
        else
        begin
            a_prev <= a_level;
            b_prev <= b_level;
            x_prev <= x_level;
            index_count_full_out <= index_count;
            if (wr_ctl)
            begin
                control <= hwdata_in[1:0];
            end
            // Velocity: software write wins, else count steps.
            if (wr_vel)
            begin
                velocity_count <= wdata[VEL_WIDTH-1:0];
            end
            else if (count_en && step)
            begin
                velocity_count <= dir_up ? velocity_count + 1'b1 : velocity_count - 1'b1;
            end
            // Index count: lower write loads both halves at once.
            if (wr_ilo)
            begin
                index_count <= {index_count_upper, wdata};
            end
            else if (count_en && index_rise)
            begin
                index_count <= dir_up ? index_count + 32'h00000001
                    : index_count - 32'h00000001;
            end
            if (wr_iup)
            begin
                index_count_upper <= wdata;
            end
            else if (rd_ilo)
            begin
                index_count_upper <= index_count[31:16];
            end
            // Interval timer: index pulse restarts it.
            if (wr_hlo)
            begin
                interval_timer <= {interval_hold_upper, wdata};
            end
            else if (timer_en)
            begin
                interval_timer <= index_rise ? 32'h00000000 : interval_timer + 32'h00000001;
            end
            if (wr_hup)
            begin
                interval_hold_upper <= wdata;
            end
            else if (rd_hlo)
            begin
                interval_hold_upper <= interval_timer[31:16];
            end
        end
    end
endmodule

/* File: hdl/ecr_defines.vh */
// Constants of the encoder counter register block.
`ifndef ECR_DEFINES_VH
`define ECR_DEFINES_VH
// ----------------------------------------------------------------
// Register byte offsets.
// ----------------------------------------------------------------
`define ECR_OFF_VELOCITY_COUNT 8'h00
`define ECR_OFF_INDEX_COUNT_UPPER 8'h04
`define ECR_OFF_INDEX_COUNT_LOWER 8'h08
`define ECR_OFF_INTERVAL_HOLD_UPPER 8'h0c
`define ECR_OFF_INTERVAL_HOLD_LOWER 8'h10
`define ECR_OFF_CONTROL 8'h14
// ----------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------
`define ECR_CTRL_COUNT_EN 0
`define ECR_CTRL_TIMER_EN 1
`define ECR_RESET_WORD 16'h0000
`define ECR_RESET_CTRL 2'h0
`define ECR_SYNC_STAGES 3
`endif

/* File: hdl/ecr_input_sync.v */
// Three-stage synchroniser with agreement filter for one pin.
`timescale 1ns/1ps
module ecr_input_sync
(
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire pin_in,
    output reg level_out
);
    // Synchroniser chain; stage 0 feeds only stage 1.
    reg [2:0] sync_chain;

    // ----------------------------------------------------------------
    // Sampling and filtering.
    // ----------------------------------------------------------------
    // A change counts once the second and third stage agree.
    always @(posedge sys_clk_in)
    begin
        if (!rst_n_in)
        begin
            sync_chain <= 3'h0;
            level_out <= 1'b0;
        end
        else
        begin
            sync_chain <= {sync_chain[1:0], pin_in};
            if (sync_chain[1] == sync_chain[2])
            begin
                level_out <= sync_chain[2];
            end
        end
    end
endmodule

/* File: verification/ecr_top_sva.sv */
// Concurrent checker for the encoder counter register block.
`timescale 1ns/1ps
module ecr_top_sva
(
    input wire sys_clk_in,
    input wire rst_n_in,
    input wire hsel_in,
    input wire [31:0] haddr_in,
    input wire [1:0] htrans_in,
    input wire hwrite_in,
    input wire [31:0] hwdata_in,
    input wire hready_in,
    input wire [31:0] hrdata_out,
    input wire hreadyout_out,
    input wire hresp_out,
    input wire [31:0] index_count_full_out
);
    reg dp_wr; // A write data phase is running.
    reg dp_rd; // A read data phase is running.
    reg [7:0] dp_addr; // Offset taken in the address phase.
    reg [15:0] vel_sh; // Last value software wrote to the velocity count.
    wire take = hsel_in && hready_in && htrans_in[1]; // Address phase accepted.
    // Track the data phase and shadow the velocity count.
    always @(posedge sys_clk_in)
    begin
        dp_wr <= rst_n_in && take && hwrite_in;
        dp_rd <= rst_n_in && take && !hwrite_in;
        dp_addr <= haddr_in[7:0];
        if (!rst_n_in)
            vel_sh <= 16'h0000;
        else if (dp_wr && dp_addr == 8'h00)
            vel_sh <= hwdata_in[15:0];
    end
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_wr_lo;
        dp_wr && dp_addr == 8'h08;
    endsequence
    sequence s_rd;
        dp_rd;
    endsequence
    rst_clear_a: assert property ($rose(rst_n_in) |-> hrdata_out == 32'h0 &&
        index_count_full_out == 32'h0) else $error("Registers not clear after reset.");
    bus_okay_a: assert property (hreadyout_out && !hresp_out)
        else $error("Slave not ready or not OKAY.");
    upper_zero_a: assert property (s_rd |-> hrdata_out[31:16] == 16'h0000)
        else $error("Read data upper half not zero.");
    idle_zero_a: assert property (!dp_rd |-> hrdata_out == 32'h0)
        else $error("Read data outside a read data phase.");
    vel_back_a: assert property (s_rd ##0 dp_addr == 8'h00 |-> hrdata_out[15:0] == vel_sh)
        else $error("Velocity count read differs from last write.");
    low_load_a: assert property (s_wr_lo |-> ##2
        index_count_full_out[15:0] == $past(hwdata_in[15:0], 2))
        else $error("Index low not loaded.");
    unmapped_zero_a: assert property (s_rd ##0 dp_addr > 8'h14 |-> hrdata_out == 32'h0)
        else $error("Unmapped offset read not zero.");
endmodule
bind ecr_top ecr_top_sva i_ecr_top_sva (.sys_clk_in, .rst_n_in, .hsel_in, .haddr_in, .htrans_in,
    .hwrite_in, .hwdata_in, .hready_in, .hrdata_out, .hreadyout_out, .hresp_out,
    .index_count_full_out);

/* File: verification/ecr_enc_model.sv */
// Behavioural quadrature encoder that drives the block's encoder pins.
`timescale 1ns/1ps
module ecr_enc_model
(
    input wire sys_clk_in,
    input wire run_in,
    output reg enc_a_out = 1'b0,
    output reg enc_b_out = 1'b0,
    output reg enc_index_out = 1'b0
);
    reg [5:0] step = 6'h00; // Position; four clocks per phase keep edges apart.
    // Step the shaft while running and form the two phases and the index.
    always @(posedge sys_clk_in)
    begin
        if (run_in)
            step <= step + 6'h01;
        enc_a_out <= step[3];
        enc_b_out <= step[3] ^ step[2];
        // The index stands four clocks so that the pin filter lets it through.
        enc_index_out <= (step[5:2] == 4'hf);
    end
endmodule

/* File: verification/encoder_counter_registers_tb_top.sv */
// Self-checking bench for the encoder counter register block.
`timescale 1ns/1ps
`include "ecr_defines.vh"
module encoder_counter_registers_tb_top;
    reg clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, run = 1'b0;
    reg [1:0] htrans = 2'b00;
    reg [31:0] haddr = 32'h0, hwdata = 32'h0, d, e, r;
    wire [31:0] hrdata, full;
    wire hready, enc_a, enc_b, enc_idx;
    integer err_count = 0, tests_run = 0, seed = 32'h4e96, i;
    ecr_top i_ecr_top (.sys_clk_in(clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
        .enc_a_in(enc_a), .enc_b_in(enc_b), .enc_index_in(enc_idx), .index_count_full_out(full));
    ecr_enc_model i_ecr_enc_model (.sys_clk_in(clk), .run_in(run), .enc_a_out(enc_a),
        .enc_b_out(enc_b), .enc_index_out(enc_idx));
    // Clock of 8 ns.
    initial forever #4 clk = ~clk;
    // Compare and count.
    task check(input [31:0] got, input [31:0] exp);
    begin
        tests_run = tests_run + 1;
        if (got !== exp)
        begin
            err_count = err_count + 1;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask
    // Print the counts and the verdict, then stop.
    task final_report;
    begin
        $display("Checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    end
    endtask
    // Wait, with a bound, for hready sampled high at a rising edge.
    task wait_ready;
        integer n;
    begin
        n = 0;
        @(posedge clk);
        while (hready !== 1'b1)
        begin
            n = n + 1;
            if (n > 100)
            begin
                err_count = err_count + 1;
                final_report;
            end
            @(posedge clk);
        end
    end
    endtask
    // One single AHB-Lite transfer of a whole word.
    task xfer(input w, input [7:0] a, input [31:0] wd);
    begin
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= w;
        wait_ready;
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready;
        r = hrdata;
    end
    endtask
    // Registers are at most 16 bits wide; upper read bits are zero.
    function [31:0] exp_word(input [31:0] v);
        exp_word = {16'h0000, v[15:0]};
    endfunction
    task rd_chk(input [7:0] a, input [31:0] v);
    begin
        xfer(1'b0, a, 32'h0);
        check(r, exp_word(v));
    end
    endtask
    // Main sequence.
    initial
    begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        run <= 1'b1;
        for (i = 0; i < 5; i = i + 1)
            rd_chk(i * 4, 0);
        $display("Test reset values done");
        for (i = 0; i < 20; i = i + 1)
        begin
            d = (i == 0) ? 32'hffffffff : $random(seed);
            e = (i == 1) ? 32'h0 : $random(seed);
            xfer(1'b1, `ECR_OFF_VELOCITY_COUNT, d);
            rd_chk(`ECR_OFF_VELOCITY_COUNT, d);
            xfer(1'b1, `ECR_OFF_INTERVAL_HOLD_UPPER, e);
            rd_chk(`ECR_OFF_INTERVAL_HOLD_UPPER, e);
            // Load the whole timer, spoil the staged upper half, then read lower
            // first: that read must bring the timer's own upper half back.
            xfer(1'b1, `ECR_OFF_INTERVAL_HOLD_LOWER, d);
            xfer(1'b1, `ECR_OFF_INTERVAL_HOLD_UPPER, ~e);
            rd_chk(`ECR_OFF_INTERVAL_HOLD_LOWER, d);
            rd_chk(`ECR_OFF_INTERVAL_HOLD_UPPER, e);
            xfer(1'b1, `ECR_OFF_INDEX_COUNT_UPPER, e);
            xfer(1'b1, `ECR_OFF_INDEX_COUNT_LOWER, d);
            repeat (2) @(posedge clk);
            check(full, {e[15:0], d[15:0]});
            // A stale staged upper half must be replaced by the lower read.
            xfer(1'b1, `ECR_OFF_INDEX_COUNT_UPPER, ~e);
            rd_chk(`ECR_OFF_INDEX_COUNT_LOWER, d);
            rd_chk(`ECR_OFF_INDEX_COUNT_UPPER, e);
        end
        $display("Test random read-back done");
        // Clear the index count, let the encoder turn with counting and the timer
        // enabled for about ten index pulses, then freeze both and look at them.
        xfer(1'b1, `ECR_OFF_INDEX_COUNT_UPPER, 32'h0);
        xfer(1'b1, `ECR_OFF_INDEX_COUNT_LOWER, 32'h0);
        xfer(1'b1, `ECR_OFF_CONTROL, 32'h3);
        rd_chk(`ECR_OFF_CONTROL, 32'h3);
        repeat (640) @(posedge clk);
        xfer(1'b1, `ECR_OFF_CONTROL, 32'h0);
        repeat (2) @(posedge clk);
        tests_run = tests_run + 1;
        if ((^full) === 1'bx || full < 32'h9 || full > 32'hb)
        begin
            err_count = err_count + 1;
            $display("FAIL %0t index count %h not near ten pulses", $time, full);
        end
        xfer(1'b0, `ECR_OFF_INTERVAL_HOLD_LOWER, 32'h0);
        tests_run = tests_run + 1;
        if ((^r) === 1'bx || r > 32'h40)
        begin
            err_count = err_count + 1;
            $display("FAIL %0t interval timer %h beyond one index period", $time, r);
        end
        $display("Test counting done");
        xfer(1'b1, 8'h18, d);
        rd_chk(8'h18, 0);
        $display("Test unmapped offset done");
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        for (i = 0; i < 4; i = i + 1)
            rd_chk(i * 4, 0);
        check(full, 32'h0);
        $display("Test mid-run reset done");
        final_report;
    end
endmodule
